/* rtl/lpl_cfg_top.sv */
// low-power level, reference select and serial port lock configuration
// How it works
// - phase code 00/01/10 picks A/B/C
// - reserved phase code 11 acts as C
// - reserved register bits change nothing
// - threshold equals full scale times level/8
// - measurement period is (lines+1)/50 seconds
// - bit0 picks internal or external reference
// - unlocked, three pin toggles activate spi
// - i2c lock bit stops further spi switching
// - any cfg2 register write under spi locks port; level writes do not
// - lock survives every power mode change
`timescale 1ns/1ps
module lpl_cfg_top
    import lpl_pkg::*;
#(
    parameter int FS_W = 24,
    parameter logic [FS_W-1:0] FULL_SCALE = '1,
    parameter int LINE_UNIT_CYC = LPL_LINE_UNIT_CYC
)(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [15:0] harmonic_cfg_i,
    input wire logic chip_select_aux_pin_i,
    input wire logic [1:0] power_mode_state_i,
    output logic [2:0] phase_ref_sel_o,
    output logic [FS_W-1:0] overcurrent_threshold_o,
    output logic measure_period_end_o,
    output logic external_reference_select_o,
    output logic spi_active_o,
    output logic port_locked_o
);

    if (FS_W < 4 || FS_W > 32 || LINE_UNIT_CYC < 2)
    begin : g_chk
        $error("lpl_cfg_top: parameter out of range");
    end

    logic [LPL_THR_W-1:0] overcurrent_threshold_eighths_r;
    logic [LPL_LINE_W-1:0] lowpower_line_periods_r;
    logic wr_level;
    logic wr_cfg2;
    logic spi_req;
    logic lock_nxt;
    logic [1:0] harmonic_timebase_phase_select;
    logic [31:0] unit_cnt_r;
    logic unit_tick_r;
    logic [LPL_LINE_W-1:0] line_cnt_r;
    logic [FS_W+LPL_THR_W-1:0] thr_prod;

    assign wr_level = reg_wr_i && (reg_addr_i == LPL_ADDR_LEVEL);
    assign wr_cfg2 = reg_wr_i && (reg_addr_i == LPL_ADDR_CFG2);

    // level register: threshold and line-period fields
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            overcurrent_threshold_eighths_r <= LPL_LEVEL_RST[LPL_THR_LSB +: LPL_THR_W];
            lowpower_line_periods_r <= LPL_LEVEL_RST[LPL_LINE_LSB +: LPL_LINE_W];
        end
        else if (wr_level)
        begin
            overcurrent_threshold_eighths_r <= reg_wdata_i[LPL_THR_LSB +: LPL_THR_W];
            lowpower_line_periods_r <= reg_wdata_i[LPL_LINE_LSB +: LPL_LINE_W];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            external_reference_select_o <= LPL_CFG2_RST[LPL_EXTREF_BIT];
        else if (wr_cfg2)
            external_reference_select_o <= reg_wdata_i[LPL_EXTREF_BIT];
    end

    lpl_toggle_det #(
        .TOGGLES(LPL_CS_TOGGLES)
    ) u_toggle (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .pin_i(chip_select_aux_pin_i),
        .enable_i(!port_locked_o && !spi_active_o),
        .spi_req_o(spi_req)
    );

    // i2c locks only by writing 1 to lock bit
    // under spi any cfg2 register write locks; level writes do not
    always_comb
    begin
        lock_nxt = port_locked_o;
        if (wr_cfg2 && (spi_active_o || reg_wdata_i[LPL_LOCK_BIT]))
            lock_nxt = 1'b1;
    end

    // power mode never touches lock or port choice
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            port_locked_o <= LPL_CFG2_RST[LPL_LOCK_BIT];
        else
            port_locked_o <= lock_nxt;
    end

    // spi becomes active after the toggle count
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            spi_active_o <= 1'b0;
        else if (spi_req && !lock_nxt)
            spi_active_o <= 1'b1;
    end

    // only bits 9:8 of the harmonic config are used
    assign harmonic_timebase_phase_select = harmonic_cfg_i[LPL_PHSEL_LSB +: LPL_PHSEL_W];

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            phase_ref_sel_o <= 3'h1;
        else
        begin
            case (harmonic_timebase_phase_select)
                LPL_PH_A: phase_ref_sel_o <= 3'h1;
                LPL_PH_B: phase_ref_sel_o <= 3'h2;
                LPL_PH_C: phase_ref_sel_o <= 3'h4;
                // reserved code behaves as phase c
                LPL_PH_RSV: phase_ref_sel_o <= 3'h4;
                default: phase_ref_sel_o <= 3'h4;
            endcase
        end
    end

    // threshold = full scale * level / 8
    assign thr_prod = FULL_SCALE * overcurrent_threshold_eighths_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            overcurrent_threshold_o <= '0;
        else
            overcurrent_threshold_o <= thr_prod[LPL_THR_DIV_SHIFT +: FS_W];
    end

    // 20 ms unit tick divider, restarted by a level write
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i || wr_level)
        begin
            unit_cnt_r <= 32'h0;
            unit_tick_r <= 1'b0;
        end
        else if (unit_cnt_r == 32'(LINE_UNIT_CYC - 1))
        begin
            unit_cnt_r <= 32'h0;
            unit_tick_r <= 1'b1;
        end
        else
        begin
            unit_cnt_r <= unit_cnt_r + 32'h1;
            unit_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i || wr_level)
        begin
            line_cnt_r <= '0;
            measure_period_end_o <= 1'b0;
        end
        else
        begin
            measure_period_end_o <= 1'b0;
            if (unit_tick_r)
            begin
                if (line_cnt_r == lowpower_line_periods_r)
                begin
                    line_cnt_r <= '0;
                    measure_period_end_o <= 1'b1;
                end
                else
                    line_cnt_r <= line_cnt_r + 1'b1;
            end
        end
    end

    // register read, reserved bits and unmapped addresses read zero
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    LPL_ADDR_LEVEL: reg_rdata_o <=
                        {lowpower_line_periods_r, overcurrent_threshold_eighths_r};
                    LPL_ADDR_CFG2: reg_rdata_o <=
                        {6'h00, port_locked_o, external_reference_select_o};
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // checks
    logic [LPL_LINE_W:0] ticks_seen_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i || wr_level || measure_period_end_o)
            ticks_seen_r <= '0;
        else if (unit_tick_r)
            ticks_seen_r <= ticks_seen_r + 1'b1;
    end

    phase_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        harmonic_timebase_phase_select == LPL_PH_B |=> phase_ref_sel_o == 3'h2)
        else $error("phase b not selected");

    rsv_phase_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        harmonic_timebase_phase_select[1] |=> phase_ref_sel_o == 3'h4)
        else $error("codes 10 and 11 must select phase c");

    thr_value_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_level ##2 !$past(wr_level) |-> overcurrent_threshold_o ==
        FS_W'(({{LPL_THR_W{1'b0}}, FULL_SCALE} *
        $past(reg_wdata_i[LPL_THR_LSB +: LPL_THR_W], 2)) >> LPL_THR_DIV_SHIFT))
        else $error("threshold does not match level");

    period_len_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        measure_period_end_o |-> $past(ticks_seen_r) == {1'b0, lowpower_line_periods_r})
        else $error("measurement period length wrong");

    ext_ref_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_cfg2 |=> external_reference_select_o == $past(reg_wdata_i[LPL_EXTREF_BIT]))
        else $error("reference select not updated");

    spi_switch_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        spi_req && !lock_nxt |=> spi_active_o)
        else $error("spi not activated after toggles");

    i2c_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_cfg2 && !spi_active_o && reg_wdata_i[LPL_LOCK_BIT] |=>
        port_locked_o ##1 (!spi_active_o)[*3])
        else $error("i2c lock failed to hold");

    spi_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_cfg2 && spi_active_o |=> port_locked_o && spi_active_o)
        else $error("spi write did not lock port");

    lock_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        port_locked_o |=> port_locked_o && $stable(spi_active_o))
        else $error("locked port choice changed");

    rsv_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == LPL_ADDR_CFG2 |=> reg_rdata_o[7:2] == 6'h00)
        else $error("reserved bits read nonzero");

    phase_a_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        harmonic_timebase_phase_select == LPL_PH_A |=> phase_ref_sel_o == 3'h1)
        else $error("phase a not selected");

    cfg2_rsv_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_cfg2 && !spi_active_o && !reg_wdata_i[LPL_LOCK_BIT] |=>
        port_locked_o == $past(port_locked_o))
        else $error("reserved config bits changed the lock");

    unmapped_rd_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i != LPL_ADDR_LEVEL && reg_addr_i != LPL_ADDR_CFG2 |=>
        reg_rvalid_o && reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    spi_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(spi_active_o) |-> $past(spi_req))
        else $error("spi active without toggle request");

    lock_no_spi_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        port_locked_o && !spi_active_o |=> !spi_active_o)
        else $error("locked i2c port switched to spi");

    ext_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !wr_cfg2 |=> $stable(external_reference_select_o))
        else $error("reference select changed without write");

endmodule

/* rtl/lpl_pkg.sv */
// constants for the low-power level and serial port lock configuration block
package lpl_pkg;

    // register addresses as seen by the serial port engine
    localparam logic [15:0] LPL_ADDR_LEVEL = 16'hEC00;
    localparam logic [15:0] LPL_ADDR_CFG2 = 16'hEC01;

    // level register fields and reset value
    localparam int LPL_THR_LSB = 0;
    localparam int LPL_THR_W = 3;
    localparam int LPL_LINE_LSB = 3;
    localparam int LPL_LINE_W = 5;
    localparam logic [7:0] LPL_LEVEL_RST = 8'h07;
    localparam int LPL_THR_DIV_SHIFT = 3;

    // second configuration register fields and reset value
    localparam int LPL_EXTREF_BIT = 0;
    localparam int LPL_LOCK_BIT = 1;
    localparam logic [7:0] LPL_CFG2_RST = 8'h00;
    localparam logic [7:0] LPL_CFG2_USED_MASK = 8'h03;

    // harmonic configuration register: phase selector position
    localparam int LPL_PHSEL_LSB = 8;
    localparam int LPL_PHSEL_W = 2;

    // phase selector codes
    typedef enum logic [1:0] {
        LPL_PH_A = 2'b00,
        LPL_PH_B = 2'b01,
        LPL_PH_C = 2'b10,
        LPL_PH_RSV = 2'b11
    } lpl_phase_e;

    // timing: one line-period unit is 1/50 s = 20 ms at a 25 ns clock
    localparam longint LPL_CLK_PERIOD_PS = 25000;
    localparam longint LPL_LINE_UNIT_PS = 64'd20_000_000_000;
    localparam int LPL_LINE_UNIT_CYC = int'(LPL_LINE_UNIT_PS / LPL_CLK_PERIOD_PS);

    // number of chip-select/aux toggles that switch to the spi port
    localparam int LPL_CS_TOGGLES = 3;

endpackage

/* rtl/lpl_toggle_det.sv */
// counts chip-select/aux pin toggles and requests the spi port
`timescale 1ns/1ps
module lpl_toggle_det
    import lpl_pkg::*;
#(
    parameter int TOGGLES = LPL_CS_TOGGLES
)(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    input wire logic enable_i,
    output logic spi_req_o
);

    if (TOGGLES < 1 || TOGGLES > 15)
    begin : g_chk
        $error("lpl_toggle_det: TOGGLES out of range");
    end

    logic pin_d_r;
    logic [3:0] cnt_r;
    logic fall;

    // a toggle is one high-to-low swing of the pin
    assign fall = pin_d_r & ~pin_i;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            pin_d_r <= 1'b1;
        else
            pin_d_r <= pin_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= 4'h0;
            spi_req_o <= 1'b0;
        end
        else
        begin
            spi_req_o <= 1'b0;
            if (!enable_i)
                cnt_r <= 4'h0;
            else if (fall)
            begin
                if (cnt_r == 4'(TOGGLES - 1))
                begin
                    cnt_r <= 4'h0;
                    spi_req_o <= 1'b1;
                end
                else
                    cnt_r <= cnt_r + 4'h1;
            end
        end
    end

endmodule

/* test/lowpower_level_and_port_lock_cfg_bench.sv */
// self-checking bench for the level and port lock block
`timescale 1ns/1ps
module lowpower_level_and_port_lock_cfg_bench;
    import lpl_pkg::*;
    logic clk, rstn, wr, rd, rv, pin, pend, ext, spi, lck, ok;
    logic [15:0] addr, hcfg;
    logic [7:0] wd, rdat, d, v;
    logic [1:0] pm;
    logic [2:0] ph;
    logic [23:0] thr;
    int num_errors, n_tests, seed, k;

    lpl_cfg_top #(.LINE_UNIT_CYC(10)) uut (.ref_clk_i(clk), .rstn_i(rstn),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .harmonic_cfg_i(hcfg),
        .chip_select_aux_pin_i(pin), .power_mode_state_i(pm),
        .phase_ref_sel_o(ph), .overcurrent_threshold_o(thr),
        .measure_period_end_o(pend), .external_reference_select_o(ext),
        .spi_active_o(spi), .port_locked_o(lck));

    lpl_host_model host (.ref_clk_i(clk), .reg_rdata_i(rdat), .reg_rvalid_i(rv),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wd),
        .pin_o(pin));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // power mode wanders all run long
    always @(posedge clk) #1 pm = 2'($urandom);

    function automatic logic [31:0] exp_thr(input logic [2:0] l);
        return 32'((27'h0FFFFFF * 27'(l)) >> 3);
    endfunction

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        host.rd(a, d, ok);
        chk("rvalid", 1, 32'(ok));
        chk("rdata", 32'(e), 32'(d));
    endtask

    task automatic wait_flag(input bit use_spi);
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
            if (k > 200)
            begin
                num_errors++;
                print_verdict();
            end
        end while ((use_spi ? spi : pend) !== 1'b1);
    endtask

    task automatic do_reset;
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
    endtask

    initial
    begin
        num_errors = 0;
        n_tests = 0;
        hcfg = 16'h0000;
        seed = $urandom(13497);
        do_reset();
        rdchk(LPL_ADDR_LEVEL, 8'h07);
        rdchk(LPL_ADDR_CFG2, 8'h00);
        rdchk(16'hEC02, 8'h00);
        chk("thr_rst", exp_thr(3'h7), 32'(thr));
        for (int c = 0; c < 4; c++)
        begin
            hcfg = 16'($urandom);
            hcfg[9:8] = 2'(c);
            repeat (2) @(posedge clk);
            #1;
            chk("phase", (c == 0) ? 1 : (c == 1) ? 2 : 4, 32'(ph));
        end
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            host.wr(LPL_ADDR_LEVEL, v);
            repeat (2) @(posedge clk);
            #1;
            chk("thr", exp_thr(v[2:0]), 32'(thr));
            rdchk(LPL_ADDR_LEVEL, v);
        end
        for (int n = 0; n < 4; n++)
        begin
            host.wr(LPL_ADDR_LEVEL, 8'((n * 5) << 3));
            wait_flag(1'b0);
            wait_flag(1'b0);
            chk("period", (n * 5 + 1) * 10, k);
        end
        for (int i = 1; i >= 0; i--)
        begin
            v = (8'($urandom) & 8'hFC) | 8'(i);
            host.wr(LPL_ADDR_CFG2, v);
            chk("extref", 32'(i), 32'(ext));
            rdchk(LPL_ADDR_CFG2, 8'(i));
        end
        host.wr(16'hEC05, 8'hFF);
        rdchk(LPL_ADDR_CFG2, 8'h00);
        host.toggle(2);
        repeat (4) @(posedge clk);
        #1;
        chk("spi_early", 0, 32'(spi));
        host.toggle(1);
        wait_flag(1'b1);
        chk("spi_wait", 1, 32'(k <= 6));
        host.wr(LPL_ADDR_CFG2, 8'h00);
        chk("spi_lock", 1, 32'(lck));
        repeat (30) @(posedge clk);
        #1;
        chk("spi_keep", 3, 32'({spi, lck}));
        do_reset();
        chk("after_rst", 0, 32'({spi, lck}));
        host.lock_i2c();
        chk("i2c_lock", 1, 32'(lck));
        host.toggle(3);
        repeat (8) @(posedge clk);
        #1;
        chk("i2c_stays", 1, 32'({spi, lck}));
        print_verdict();
    end
endmodule

/* test/lpl_host_model.sv */
// host side model: register strobes and chip-select/aux pin
`timescale 1ns/1ps
module lpl_host_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic pin_o
);
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 16'h0000;
        reg_wdata_o = 8'h00;
        pin_o = 1'b1;
    end

    // idle address shows the inverse of the last access, idle data the inverse of the last write
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        ok = reg_rvalid_i;
        d = reg_rdata_i;
    endtask

    task automatic toggle(input int n);
        repeat (n)
        begin
            @(posedge ref_clk_i);
            #1;
            pin_o = 1'b0;
            repeat (2) @(posedge ref_clk_i);
            #1;
            pin_o = 1'b1;
        end
    endtask

    task automatic lock_i2c;
        wr(16'hEC01, 8'h02);
    endtask
endmodule
